/* File: asma_converter.sv */
/*
 * serial/message converter: queues received message payloads to an async
 * serial transmitter and assembles serial characters into outgoing messages.
 * assumes all inputs are synchronous to clk and that the transport engine
 * presents message bytes in order with a last marker.
 */
// Operation
// [RL1] datagrams dropped on congestion or port down
// [RL2] confirmed messages dropped unacknowledged then
// [RL3] port status taken only from status input
// [RL4] both kinds queued strictly in arrival order
// [RL5] both kinds enqueued when all sides operative
// [RL6] full incoming queue loses characters, no flow control
// [RL7] assembled messages discarded while transport down
// [RL8] no serial data accepted while port down
// [RL9] release buffer at maximum message length
// [RL10] release on character in enabled class
// [RL11] idle timer restarts per character, releases
// [RL12] release requests datagram or confirmed message
// [RL13] line rate 300 to 64000, default 9600
// [RL14] five to eight data bits, default eight
// [RL15] one or two stop bits, default one
// [RL16] even, odd, mark, space or none parity
// [RL17] eight bit send mask, zero disables
// [RL18] low mask bits select named classes
// [RL19] high mask bits select remaining classes
// [RL20] idle timer counts 0..65535 twentieths
// [RL21] no timer and no mask: sixty seconds
// [RL22] trigger character ends its message
// [RL23] attached device uses the same format
// [RL24] each character matches one class only
`timescale 1ns/100ps
module asma_converter
	import asma_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES, // cycles per 1/20 s tick, shorten in simulation
	parameter int DEPTH_AW = QUEUE_AW     // address bits of each byte memory
) (
	input wire logic clk,
	input wire logic rst_n,
	// configuration
	input wire logic [16:0] line_rate_bps,
	input wire logic [1:0] data_bit_count,
	input wire logic stop_bit_count,
	input wire logic [2:0] parity_mode,
	input wire logic [7:0] send_char_mask,
	input wire logic [15:0] idle_send_timer,
	input wire logic [15:0] max_message_length,
	input wire logic confirmed_mode,
	// status
	input wire logic port_operative,
	input wire logic transport_up,
	// serial pins
	input wire logic serial_rx,
	output logic serial_tx,
	// messages from transport
	input wire logic dn_valid,
	input wire logic [7:0] dn_data,
	input wire logic dn_last,
	input wire logic dn_kind,
	output logic dn_ready,
	output logic dn_ack,
	output logic dn_nak,
	// messages to transport
	output logic up_valid,
	output logic [7:0] up_data,
	output logic up_last,
	output logic up_kind,
	input wire logic up_ready,
	output logic char_lost
);
	localparam int PW = DEPTH_AW + 1; // pointer width with wrap bit
	localparam logic [PW-1:0] DEPTH = PW'(1 << DEPTH_AW);

	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asma_rx_t;
	typedef enum {TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_PAR, TX_STOP} asma_tx_t;
	typedef enum {UP_FILL, UP_FETCH, UP_SHOW} asma_up_t;

	asma_mem_if #(.AW(DEPTH_AW), .DW(8)) dq (); // outgoing serial queue
	asma_mem_if #(.AW(DEPTH_AW), .DW(8)) aq (); // assembly buffer

	asma_mem #(.AW(DEPTH_AW), .DW(8)) dq_mem (.clk(clk), .port(dq));
	asma_mem #(.AW(DEPTH_AW), .DW(8)) aq_mem (.clk(clk), .port(aq));

	// parity of a character under a given mode
	function automatic logic par_of(input logic [7:0] d, input logic [2:0] m);
		logic p;
		p = 1'b0;
		unique case (asma_parity_t'(m))
			PAR_EVEN: p = ^d;
			PAR_ODD: p = ~^d;
			PAR_MARK: p = 1'b1;
			default: p = 1'b0; // space, none and illegal codes
		endcase
		return p;
	endfunction

	// ---------------- format decode ----------------
	logic [16:0] rate_eff;     // clamped line rate
	logic [17:0] bit_cycles;   // clock cycles per serial bit
	logic [3:0] nbits;         // data bits per character
	logic par_on;              // parity bit present
	logic [15:0] max_len;      // effective release length

	// rate selection, zero picks the default
	always_comb begin
		if (line_rate_bps == 17'd0) begin
			rate_eff = RATE_DEFAULT; // RL13
		end else if (line_rate_bps < RATE_MIN) begin
			rate_eff = RATE_MIN;
		end else if (line_rate_bps > RATE_MAX) begin
			rate_eff = RATE_MAX;
		end else begin
			rate_eff = line_rate_bps;
		end
	end

	// divider result registered; a rate change takes effect one cycle later, at the next bit reload
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bit_cycles <= 18'(CLK_HZ / int'(RATE_DEFAULT));
		end else begin
			bit_cycles <= 18'(CLK_HZ / int'(rate_eff)); // RL13
		end
	end

	// zero code means eight data bits
	assign nbits = (data_bit_count == 2'd0) ? DATA_BITS_DEFAULT :
		DATA_BITS_BASE + 4'(data_bit_count); // RL14
	assign par_on = (asma_parity_t'(parity_mode) != PAR_NONE); // RL16
	// zero length means default, never beyond memory size
	assign max_len = (max_message_length == 16'd0) ? MAX_LEN_DEFAULT :
		((max_message_length > 16'(DEPTH)) ? 16'(DEPTH) : max_message_length);

	// ---------------- serial receiver ----------------
	asma_rx_t rx_state;
	logic [17:0] rx_cnt;       // bit time countdown
	logic [3:0] rx_idx;        // data bit index
	logic [7:0] rx_shift;      // assembled character, unused bits zero
	logic rx_bad;              // parity error seen
	logic rx_valid;            // one-cycle pulse, good character
	logic [7:0] rx_char;       // character delivered with rx_valid

	// mid-bit sampling; only the first stop bit is checked, a second one
	// simply looks like idle line
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_state <= RX_IDLE;
			rx_cnt <= 18'h0;
			rx_idx <= 4'h0;
			rx_shift <= 8'h00;
			rx_bad <= 1'b0;
			rx_valid <= 1'b0;
			rx_char <= 8'h00;
		end else begin
			rx_valid <= 1'b0;
			unique case (rx_state)
				RX_IDLE: begin
					if (!serial_rx) begin
						rx_cnt <= bit_cycles >> 1;
						rx_state <= RX_START;
					end
				end
				RX_START: begin
					if (rx_cnt != 18'h0) begin
						rx_cnt <= rx_cnt - 18'h1;
					end else if (!serial_rx) begin
						rx_cnt <= bit_cycles - 18'h1;
						rx_idx <= 4'h0;
						rx_shift <= 8'h00;
						rx_bad <= 1'b0;
						rx_state <= RX_DATA;
					end else begin
						rx_state <= RX_IDLE; // glitch, not a start bit
					end
				end
				RX_DATA: begin
					if (rx_cnt != 18'h0) begin
						rx_cnt <= rx_cnt - 18'h1;
					end else begin
						rx_shift[rx_idx[2:0]] <= serial_rx;
						rx_cnt <= bit_cycles - 18'h1;
						rx_idx <= rx_idx + 4'h1;
						if (rx_idx == nbits - 4'h1) begin // RL14
							rx_state <= par_on ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (rx_cnt != 18'h0) begin
						rx_cnt <= rx_cnt - 18'h1;
					end else begin
						rx_bad <= (serial_rx != par_of(rx_shift, parity_mode)); // RL16
						rx_cnt <= bit_cycles - 18'h1;
						rx_state <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_cnt != 18'h0) begin
						rx_cnt <= rx_cnt - 18'h1;
					end else begin
						// framing or parity errors drop the character
						rx_valid <= serial_rx && !rx_bad;
						rx_char <= rx_shift;
						rx_state <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// ---------------- downstream queue ----------------
	logic [PW-1:0] wr_ptr;     // speculative write pointer
	logic [PW-1:0] commit_ptr; // end of complete messages
	logic [PW-1:0] rd_ptr;     // next byte to transmit
	logic dropping;            // current message is being discarded
	logic q_full;
	logic drop_now;            // this byte cannot be kept

	assign q_full = ((wr_ptr - rd_ptr) == DEPTH);
	assign drop_now = dropping || q_full || !port_operative; // RL1 RL2 RL3
	assign dn_ready = 1'b1; // never stalls: overflow drops instead
	assign dq.we = dn_valid && !drop_now;
	assign dq.waddr = wr_ptr[DEPTH_AW-1:0];
	assign dq.wdata = dn_data;

	// message capture; a message is kept whole or not at all, bytes go to the
	// single queue in arrival order regardless of kind
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			commit_ptr <= '0;
			dropping <= 1'b0;
			dn_ack <= 1'b0;
			dn_nak <= 1'b0;
		end else begin
			dn_ack <= 1'b0;
			dn_nak <= 1'b0;
			if (dn_valid) begin
				if (drop_now) begin
					wr_ptr <= commit_ptr; // RL1 rewind partial message
				end else begin
					wr_ptr <= wr_ptr + PW'(1); // RL4 RL5
				end
				if (dn_last) begin
					dropping <= 1'b0;
					if (!drop_now) begin
						commit_ptr <= wr_ptr + PW'(1); // RL4
						dn_ack <= (dn_kind == MSG_CONFIRMED);
					end else begin
						dn_nak <= (dn_kind == MSG_CONFIRMED); // RL2 no ack
					end
				end else begin
					dropping <= drop_now;
				end
			end
		end
	end

	// ---------------- serial transmitter ----------------
	asma_tx_t tx_state;
	logic [17:0] tx_cnt;
	logic [3:0] tx_idx;
	logic [7:0] tx_shift;
	logic tx_stop2;            // second stop bit still owed

	assign dq.raddr = rd_ptr[DEPTH_AW-1:0];

	// drains committed bytes one character at a time
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_state <= TX_IDLE;
			tx_cnt <= 18'h0;
			tx_idx <= 4'h0;
			tx_shift <= 8'h00;
			tx_stop2 <= 1'b0;
			rd_ptr <= '0;
			serial_tx <= 1'b1;
		end else begin
			unique case (tx_state)
				TX_IDLE: begin
					serial_tx <= 1'b1;
					if (rd_ptr != commit_ptr) begin
						tx_state <= TX_LOAD; // memory read in flight
					end
				end
				TX_LOAD: begin
					tx_shift <= dq.rdata;
					rd_ptr <= rd_ptr + PW'(1);
					serial_tx <= 1'b0;
					tx_cnt <= bit_cycles - 18'h1;
					tx_state <= TX_START;
				end
				TX_START: begin
					if (tx_cnt != 18'h0) begin
						tx_cnt <= tx_cnt - 18'h1;
					end else begin
						serial_tx <= tx_shift[0];
						tx_idx <= 4'h1;
						tx_cnt <= bit_cycles - 18'h1;
						tx_state <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (tx_cnt != 18'h0) begin
						tx_cnt <= tx_cnt - 18'h1;
					end else begin
						tx_cnt <= bit_cycles - 18'h1;
						tx_idx <= tx_idx + 4'h1;
						if (tx_idx == nbits) begin // RL14
							tx_stop2 <= stop_bit_count; // RL15
							if (par_on) begin
								// mask unused high bits so they do not affect parity
								serial_tx <= par_of(tx_shift & 8'(8'hff >> (4'h8 - nbits)),
									parity_mode); // RL16
								tx_state <= TX_PAR;
							end else begin
								serial_tx <= 1'b1;
								tx_state <= TX_STOP;
							end
						end else begin
							serial_tx <= tx_shift[tx_idx[2:0]];
						end
					end
				end
				TX_PAR: begin
					if (tx_cnt != 18'h0) begin
						tx_cnt <= tx_cnt - 18'h1;
					end else begin
						serial_tx <= 1'b1;
						tx_cnt <= bit_cycles - 18'h1;
						tx_state <= TX_STOP;
					end
				end
				TX_STOP: begin
					if (tx_cnt != 18'h0) begin
						tx_cnt <= tx_cnt - 18'h1;
					end else if (tx_stop2) begin
						tx_stop2 <= 1'b0; // RL15
						tx_cnt <= bit_cycles - 18'h1;
					end else begin
						tx_state <= TX_IDLE;
					end
				end
			endcase
		end
	end

	// ---------------- idle tick ----------------
	logic [31:0] tick_cnt;
	logic tick;                // one cycle every 1/20 s

	// free running 1/20 s prescaler
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_cnt <= 32'h0;
			tick <= 1'b0;
		end else begin
			tick <= (tick_cnt == 32'(TICK_LEN - 1));
			tick_cnt <= (tick_cnt == 32'(TICK_LEN - 1)) ? 32'h0 : tick_cnt + 32'h1;
		end
	end

	// ---------------- assembly and release ----------------
	asma_up_t up_state;
	logic [15:0] asm_count;    // characters held
	logic [15:0] out_idx;      // next byte to hand up
	logic [15:0] idle_ticks;   // ticks since the last character
	logic [15:0] idle_limit;   // ticks before an idle release
	logic idle_on;
	logic accept;              // character written this cycle
	logic [15:0] next_count;
	logic release_now;

	// zero timer with zero mask falls back to sixty seconds
	assign idle_on = (idle_send_timer != 16'h0) || (send_char_mask == 8'h00); // RL17 RL21
	assign idle_limit = (idle_send_timer != 16'h0) ? idle_send_timer :
		FALLBACK_IDLE_TICKS; // RL20 RL21
	// no data taken while the port is down or while a message drains
	assign accept = rx_valid && port_operative && (up_state == UP_FILL); // RL6 RL8
	assign next_count = asm_count + 16'h1;
	assign release_now = (up_state == UP_FILL) && (
		(accept && next_count >= max_len) || // RL9
		(accept && (asma_char_class(rx_char) & send_char_mask) != 8'h00) || // RL10 RL18 RL19 RL22 RL24
		(!accept && idle_on && asm_count != 16'h0 && idle_ticks >= idle_limit)); // RL11

	assign aq.we = accept;
	assign aq.waddr = asm_count[DEPTH_AW-1:0];
	assign aq.wdata = rx_char;
	assign aq.raddr = out_idx[DEPTH_AW-1:0];
	assign char_lost = rx_valid && port_operative && !accept; // RL6

	// idle timer, restarted by every accepted character
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			idle_ticks <= 16'h0;
		end else if (accept || up_state != UP_FILL) begin
			idle_ticks <= 16'h0; // RL11
		end else if (tick && idle_ticks != 16'hffff) begin
			idle_ticks <= idle_ticks + 16'h1;
		end
	end

	// fill, then hand the buffer up one byte at a time
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			up_state <= UP_FILL;
			asm_count <= 16'h0;
			out_idx <= 16'h0;
			up_valid <= 1'b0;
			up_data <= 8'h00;
			up_last <= 1'b0;
			up_kind <= MSG_DATAGRAM;
		end else begin
			unique case (up_state)
				UP_FILL: begin
					if (release_now) begin
						out_idx <= 16'h0;
						if (!transport_up) begin
							asm_count <= 16'h0; // RL7 message lost
						end else begin
							asm_count <= accept ? next_count : asm_count; // RL22
							up_kind <= confirmed_mode ? MSG_CONFIRMED : MSG_DATAGRAM; // RL12
							up_state <= UP_FETCH;
						end
					end else if (accept) begin
						asm_count <= next_count;
					end
				end
				UP_FETCH: begin
					// read address was presented this cycle
					up_state <= UP_SHOW;
				end
				UP_SHOW: begin
					if (!up_valid) begin
						up_valid <= 1'b1;
						up_data <= aq.rdata;
						up_last <= (out_idx == asm_count - 16'h1);
					end else if (up_ready) begin
						up_valid <= 1'b0;
						if (up_last) begin
							asm_count <= 16'h0;
							up_state <= UP_FILL;
						end else begin
							out_idx <= out_idx + 16'h1;
							up_state <= UP_FETCH;
						end
					end
				end
			endcase
		end
	end
endmodule

/* File: asma_pkg.sv */
/*
 * shared constants, parity mode and message kind types and the character-class decoder
 * for the serial/message converter.
 * assumes a single 40 MHz system clock; no timescale needed here.
 */
package asma_pkg;

	// system clock and derived timing
	localparam int CLK_HZ = 40_000_000;           // clock rate in hertz
	localparam int TICK_PER_SEC = 20;             // idle timer unit is 1/20 s
	localparam int TICK_CYCLES = CLK_HZ / TICK_PER_SEC; // cycles per timer tick
	localparam int FALLBACK_IDLE_SEC = 60;        // idle fallback with no timer and no mask
	localparam logic [15:0] FALLBACK_IDLE_TICKS = 16'(FALLBACK_IDLE_SEC * TICK_PER_SEC);

	// line rate limits in bits per second
	localparam logic [16:0] RATE_MIN = 17'd300;
	localparam logic [16:0] RATE_MAX = 17'd64000;
	localparam logic [16:0] RATE_DEFAULT = 17'd9600;

	// character format codes: all-zero configuration gives the defaults
	localparam logic [3:0] DATA_BITS_DEFAULT = 4'h8;  // code 0 selects eight bits
	localparam logic [3:0] DATA_BITS_BASE = 4'h4;     // codes 1..3 give five..seven bits

	// message sizing
	localparam logic [15:0] MAX_LEN_DEFAULT = 16'd1400; // used when length input is zero
	localparam int QUEUE_AW = 11;                       // address bits of each byte memory

	// character parity modes; none is the first, so a zero code means none
	typedef enum logic [2:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_MARK, PAR_SPACE} asma_parity_t;

	// kind of transport message on either side
	typedef enum logic {MSG_DATAGRAM, MSG_CONFIRMED} asma_kind_t;

	// class of a received character, one hot for codes below 0x80 and zero above, matching the send mask bit order
	function automatic logic [7:0] asma_char_class(input logic [7:0] c);
		logic [7:0] cls;
		cls = 8'h00;
		if ((c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5a) ||
			(c >= 8'h61 && c <= 8'h7a)) begin
			cls = 8'h01; // letters and digits
		end else if (c == 8'h0d) begin
			cls = 8'h02; // carriage return
		end else if (c == 8'h1b || c == 8'h07 || c == 8'h05 || c == 8'h06) begin
			cls = 8'h04; // escape, bell, enquiry, acknowledge
		end else if (c == 8'h7f || c == 8'h18 || c == 8'h12) begin
			cls = 8'h08; // delete, cancel, device control two
		end else if (c == 8'h03 || c == 8'h04) begin
			cls = 8'h10; // end of text, end of transmission
		end else if (c >= 8'h09 && c <= 8'h0c) begin
			cls = 8'h20; // tab, line feed, vertical tab, form feed
		end else if (c < 8'h20) begin
			cls = 8'h40; // remaining control codes
		end else if (c <= 8'h7f) begin
			cls = 8'h80; // remaining printable codes
		end
		return cls;
	endfunction

endpackage

/* File: asma_mem_if.sv */
/*
 * port bundle between the converter and one of its byte memories.
 * assumes one clock shared by both ends; read data lag the address by one edge.
 */
`timescale 1ns/100ps
interface asma_mem_if #(parameter int AW = 11, parameter int DW = 8);
	logic we;            // write strobe
	logic [AW-1:0] waddr; // write address
	logic [DW-1:0] wdata; // write data
	logic [AW-1:0] raddr; // read address
	logic [DW-1:0] rdata; // registered read data
	modport user (output we, waddr, wdata, raddr, input rdata);
	modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

/* File: asma_mem.sv */
/*
 * simple dual-port byte memory with registered read data.
 * assumes the user holds the read address one edge before taking rdata.
 */
`timescale 1ns/100ps
module asma_mem #(
	parameter int AW = 11,
	parameter int DW = 8
) (
	input wire logic clk,
	asma_mem_if.mem port
);
	// storage array, no reset so it maps to block memory
	logic [DW-1:0] store [0:(1<<AW)-1];

	// write side
	always_ff @(posedge clk) begin
		if (port.we) begin
			store[port.waddr] <= port.wdata;
		end
	end

	// read side, always registered
	always_ff @(posedge clk) begin
		port.rdata <= store[port.raddr];
	end
endmodule

/* File: asma_converter_asserts.sv */
/*
 * concurrent checks on the converter's message and serial ports.
 * assumes one clock, clk, and the synchronous active-low reset rst_n.
 */
`timescale 1ns/100ps
module asma_converter_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic confirmed_mode,
	input wire logic port_operative,
	input wire logic serial_tx,
	input wire logic dn_valid,
	input wire logic dn_last,
	input wire logic dn_kind,
	input wire logic dn_ack,
	input wire logic dn_nak,
	input wire logic up_valid,
	input wire logic [7:0] up_data,
	input wire logic up_last,
	input wire logic up_kind,
	input wire logic up_ready,
	input wire logic char_lost
);
	// every check shares the one clock and is quiet while reset is low
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_ack_cause: assert property (dn_ack |-> $past(dn_valid && dn_last && dn_kind))
		else $error("ack without a closing confirmed byte");
	a_nak_cause: assert property (dn_nak |-> $past(dn_valid && dn_last && dn_kind))
		else $error("nak without a closing confirmed byte");
	a_ack_nak_excl: assert property (!(dn_ack && dn_nak))
		else $error("ack and nak together");
	a_down_no_ack: assert property ((dn_valid && dn_last && dn_kind && !port_operative) |=> !dn_ack)
		else $error("message acked while port down");
	a_dg_no_resp: assert property ((dn_valid && dn_last && !dn_kind) |=> !(dn_ack || dn_nak))
		else $error("datagram answered");
	// a stalled byte must not move under the engine
	a_up_hold: assert property ((up_valid && !up_ready) |=> up_valid && $stable(up_data)
		&& $stable(up_last) && $stable(up_kind))
		else $error("offered byte changed before take");
	a_up_kind: assert property (up_valid |-> up_kind == confirmed_mode)
		else $error("message kind differs from service");
	a_up_gap: assert property ((up_valid && up_ready) |=> !up_valid)
		else $error("valid held after take");
	// a start bit is hundreds of clocks long at any legal rate
	a_start_width: assert property ($fell(serial_tx) |-> !serial_tx [*8])
		else $error("start bit too short");
	// a lost character is flagged once, never held into the next cycle
	a_lost_pulse: assert property (char_lost |=> !char_lost)
		else $error("character loss flagged two cycles running");
endmodule

bind asma_converter asma_converter_asserts u_asma_converter_asserts (.clk(clk), .rst_n(rst_n),
	.confirmed_mode(confirmed_mode), .port_operative(port_operative), .serial_tx(serial_tx),
	.dn_valid(dn_valid), .dn_last(dn_last), .dn_kind(dn_kind), .dn_ack(dn_ack),
	.dn_nak(dn_nak), .up_valid(up_valid), .up_data(up_data), .up_last(up_last),
	.up_kind(up_kind), .up_ready(up_ready), .char_lost(char_lost));

/* File: asma_serial_dev.sv */
/*
 * behavioural attached serial device: sends characters on request and
 * decodes every frame the converter transmits.
 * assumes its format inputs match the converter configuration.
 */
`timescale 1ns/100ps
module asma_serial_dev #(
	parameter int BIT = 625 // clocks per bit at the chosen line rate
) (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out,
	input wire logic [3:0] nbits,
	input wire logic [2:0] par,
	input wire logic two_stop
);
	logic [7:0] got [$]; // characters decoded from the converter
	int bad = 0; // frames with a parity or stop fault

	// parity bit for the configured mode over the masked data
	function automatic logic par_bit(input logic [7:0] d);
		case (par)
			3'd1: return ^d;
			3'd2: return ~^d;
			3'd3: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// one full frame, lsb first, same format as the converter
	task automatic send_char(input logic [7:0] c);
		logic [7:0] d;
		int i;
		d = c & (8'hff >> (8 - nbits));
		@(negedge clk);
		line_out = 1'b0;
		repeat (BIT) @(negedge clk);
		for (i = 0; i < nbits; i++) begin
			line_out = d[i];
			repeat (BIT) @(negedge clk);
		end
		if (par != 3'd0) begin
			line_out = par_bit(d);
			repeat (BIT) @(negedge clk);
		end
		line_out = 1'b1;
		repeat (two_stop ? 2 * BIT : BIT) @(negedge clk);
	endtask

	// idle line is high until a frame starts
	initial line_out = 1'b1;

	// receiver samples mid-bit; the second stop bit is not checked
	initial begin
		logic [7:0] d;
		int i;
		forever begin
			@(negedge line_in);
			repeat (BIT / 2) @(posedge clk);
			d = 8'h00;
			for (i = 0; i < nbits; i++) begin
				repeat (BIT) @(posedge clk);
				d[i] = line_in;
			end
			if (par != 3'd0) begin
				repeat (BIT) @(posedge clk);
				if (line_in !== par_bit(d)) bad++;
			end
			repeat (BIT) @(posedge clk);
			if (line_in !== 1'b1) bad++;
			got.push_back(d);
		end
	end
endmodule

/* File: tb_top.sv */
/*
 * self-checking bench for the converter: transport side driven by tasks,
 * serial side by the attached device model.
 * assumes a 40 MHz clock and the fastest line rate to keep the run short.
 */
`timescale 1ns/100ps
module tb_top;
	import asma_pkg::*;
	logic clk = 0, rst_n;
	logic [16:0] rate; // 625 clocks per bit at 64000
	logic [1:0] dbc;
	logic stp, conf, port_op, tr_up, up_ready;
	logic [2:0] par;
	logic [7:0] mask, dn_data;
	logic [15:0] tmr, len;
	logic dn_valid, dn_last, dn_kind;
	logic rx, tx, dn_ready, dn_ack, dn_nak, up_valid, up_last, up_kind, char_lost;
	logic [7:0] up_data;
	logic [3:0] nb;
	logic [9:0] upq [$]; // taken bytes as kind, last, data
	int err_total = 0, n_tests = 0, n_ack = 0, n_nak = 0, n_lost = 0;

	assign nb = (dbc == 2'd0) ? 4'd8 : 4'(dbc) + 4'd4;
	initial forever #12.5 clk = ~clk;

	// short tick so the idle timers fit the run
	asma_converter #(.TICK_LEN(5)) u_asma_converter (.clk(clk), .rst_n(rst_n),
		.line_rate_bps(rate), .data_bit_count(dbc), .stop_bit_count(stp), .parity_mode(par),
		.send_char_mask(mask), .idle_send_timer(tmr), .max_message_length(len),
		.confirmed_mode(conf), .port_operative(port_op), .transport_up(tr_up),
		.serial_rx(rx), .serial_tx(tx), .dn_valid(dn_valid), .dn_data(dn_data),
		.dn_last(dn_last), .dn_kind(dn_kind), .dn_ready(dn_ready), .dn_ack(dn_ack),
		.dn_nak(dn_nak), .up_valid(up_valid), .up_data(up_data), .up_last(up_last),
		.up_kind(up_kind), .up_ready(up_ready), .char_lost(char_lost));
	asma_serial_dev #(.BIT(625)) u_asma_serial_dev (.clk(clk), .line_in(tx), .line_out(rx),
		.nbits(nb), .par(par), .two_stop(stp));

	// transport engine side: record takes and count one-cycle pulses
	always @(posedge clk) begin
		if (up_valid === 1'b1 && up_ready) upq.push_back({up_kind, up_last, up_data});
		if (dn_ack === 1'b1) n_ack++;
		if (dn_nak === 1'b1) n_nak++;
		if (char_lost === 1'b1) n_lost++;
	end

	task chk(input logic [15:0] a, input logic [15:0] e);
		n_tests++;
		if (a !== e) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, a, e);
		end
	endtask

	// one byte, l marks the last; hold keeps valid up for a back-to-back follower
	task dn(input logic [7:0] d, input logic k, input bit hold, input logic l);
		@(negedge clk);
		dn_valid = 1;
		dn_data = d;
		dn_last = l;
		dn_kind = k;
		if (!hold) begin
			@(negedge clk);
			dn_valid = 0;
		end
	endtask

	task up_exp(input logic [9:0] e);
		int i;
		for (i = 0; i < 9000 && upq.size() == 0; i++) @(negedge clk);
		if (upq.size() == 0) chk(16'h0, 16'h1);
		else chk(16'(upq.pop_front()), 16'(e));
	endtask

	task tx_wait(input int n);
		int i;
		for (i = 0; i < 20000 && u_asma_serial_dev.got.size() < n; i++) @(negedge clk);
		chk(16'(u_asma_serial_dev.got.size()), 16'(n));
	endtask

	task close_out;
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		close_out;
	end

	initial begin
		// every stimulus starts from a known level before reset lifts
		{rst_n, stp, conf, dn_valid, dn_last, dn_kind} = 6'h00;
		{dbc, par, mask, dn_data, tmr, len} = 53'h0;
		{port_op, tr_up, up_ready} = 3'h7;
		rate = 17'd64000;
		repeat (2) @(negedge clk);
		rst_n = 1;
		@(negedge clk);
		chk({tx, up_valid, dn_ack, dn_nak, char_lost, dn_ready}, 16'h21);
		// back-to-back datagram then confirmed message
		dn(8'h55, 0, 1, 1);
		dn(8'ha3, 1, 0, 1);
		tx_wait(2);
		chk(u_asma_serial_dev.got[0], 8'h55);
		chk(u_asma_serial_dev.got[1], 8'ha3);
		chk(n_ack, 1);
		// port down: a two-byte confirmed message and a datagram, both dropped
		port_op = 0;
		dn(8'h66, 1, 1, 0);
		dn(8'h67, 1, 1, 1);
		dn(8'h77, 0, 0, 1);
		repeat (100) @(negedge clk);
		chk(tx, 1);
		port_op = 1;
		chk(n_nak, 1);
		chk(n_ack, 1);
		chk(u_asma_serial_dev.got.size(), 2);
		// trigger on carriage return, trigger byte ends the message
		mask = 8'h02;
		u_asma_serial_dev.send_char(8'h61);
		u_asma_serial_dev.send_char(8'h0d);
		up_exp({2'b00, 8'h61});
		up_exp({2'b01, 8'h0d});
		// length release in confirmed service; idle time longer than a frame
		conf = 1;
		mask = 8'h00;
		tmr = 16'd2000;
		len = 16'd2;
		u_asma_serial_dev.send_char(8'h41);
		u_asma_serial_dev.send_char(8'h42);
		up_exp({2'b10, 8'h41});
		up_exp({2'b11, 8'h42});
		chk(upq.size(), 0);
		conf = 0;
		len = 16'd0;
		// idle timer; 0x01 is a control code, not in the printable class
		tmr = 16'd2;
		mask = 8'h80;
		u_asma_serial_dev.send_char(8'h01);
		up_exp({2'b01, 8'h01});
		// no timer and no mask: long fallback of 1200 ticks
		tmr = 16'd0;
		mask = 8'h00;
		u_asma_serial_dev.send_char(8'h20);
		repeat (5000) @(negedge clk);
		chk(upq.size(), 0);
		up_exp({2'b01, 8'h20});
		// serial port down, then transport down
		mask = 8'h01;
		port_op = 0;
		u_asma_serial_dev.send_char(8'h33);
		repeat (100) @(negedge clk);
		chk(upq.size(), 0);
		port_op = 1;
		tr_up = 0;
		u_asma_serial_dev.send_char(8'h34);
		repeat (100) @(negedge clk);
		chk(upq.size(), 0);
		tr_up = 1;
		// engine stalls: the character behind a draining message is lost
		up_ready = 0;
		u_asma_serial_dev.send_char(8'h78);
		u_asma_serial_dev.send_char(8'h79);
		repeat (20) @(negedge clk);
		chk(n_lost, 1);
		up_ready = 1;
		up_exp({2'b01, 8'h78});
		repeat (50) @(negedge clk);
		chk(upq.size(), 0);
		// seven bits, odd parity, two stops both ways
		dbc = 2'd3;
		par = 3'd2;
		stp = 1;
		repeat (4) @(negedge clk);
		dn(8'h5a, 0, 0, 1);
		tx_wait(3);
		chk(u_asma_serial_dev.got[2], 8'h5a);
		chk(u_asma_serial_dev.bad, 0);
		u_asma_serial_dev.send_char(8'h6b);
		up_exp({2'b01, 8'h6b});
		close_out;
	end
endmodule
